// ==== design/can_irq_defines.vh ====
// Constants of the interrupt enable and arbitration-loss capture block
//
// Behaviour
// - Sleep request while bus busy or interrupt pending raises wake-up interrupt.
// - Receive flag follows receive buffer status and enable; flag read keeps it.
// - Release command drops receive flag briefly; it returns if messages remain.
// - Enable register: eight bits, readable and writable at all times.
// - Enable bit 7 lets bus errors request an interrupt.
// - Enable bit 6 lets arbitration loss request an interrupt.
// - Enable bit 5 lets error active/passive changes request an interrupt.
// - Enable bit 4 lets wake-up from sleep request an interrupt.
// - Enable bit 3 lets data overrun rising request an interrupt.
// - Enable bit 2 lets error or bus status changes request an interrupt.
// - Enable bit 1 lets transmit buffer release request an interrupt.
// - Enable bit 0 lets receive buffer full request an interrupt.
// - Clearing receive enable drops receive flag and output at once.
// - Capture register is read-only; top three bits read zero.
// - Arbitration loss sets flag if enabled and latches bit position.
// - Captured position frozen until capture register read once, then re-armed.
// - Reading flag register clears the arbitration-loss flag.
// - No new arbitration-loss interrupt until capture register read since capture.
// - Position is binary frame bit number: ID1-11, SRTR, IDE, ID12-29, RTR.
// - SRTR code stands for RTR in standard frames; higher codes extended only.
// - Interrupt output active whenever any flag register bit is set.
// - Reading flag register clears every flag it reported at setup except the receive flag.
`ifndef CAN_IRQ_DEFINES_VH
`define CAN_IRQ_DEFINES_VH

// Register indices; byte address is four times the index
`define IDX_CTRL 6'h00
`define IDX_CMD 6'h01
`define IDX_FLAGS 6'h03
`define IDX_ENABLE 6'h04
`define IDX_ARBPOS 6'h0b

// Flag and enable bit positions
`define BIT_BUS_ERR 7
`define BIT_ARB_LOSS 6
`define BIT_ERR_PASSIVE 5
`define BIT_WAKEUP 4
`define BIT_OVERRUN 3
`define BIT_ERR_WARN 2
`define BIT_TX_DONE 1
`define BIT_RX 0

// Control and command fields
`define CTRL_SLEEP_BIT 4
`define CMD_RELEASE_BIT 2

// Reset values
`define ENABLE_RST 8'h00
`define ARBPOS_RST 5'h00
`define FLAGS_RST 7'h00

`endif

// ==== design/can_irq_enable_arb_capture.v ====
// Interrupt enable gating, flag register and arbitration-loss capture
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "can_irq_defines.vh"

module can_irq_enable_arb_capture (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Controller events and status
    input wire busErrorEvt,
    input wire arbLossEvt,
    input wire [4:0] arbLossBitPos,
    input wire errPassive,
    input wire errStatus,
    input wire busStatus,
    input wire overrunStatus,
    input wire txBufReleased,
    input wire rxBufFull,
    input wire busActive,
    // Controller outputs
    output reg intOut_b,
    output reg sleepMode,
    output reg rxRelease
);

    // Enable, flags and capture state
    reg [7:0] enable_q;
    reg [7:0] enable_d;
    reg [7:1] flags_q;
    wire [7:1] flags_d;
    reg rxFlag_q;
    reg rxFlag_d;
    reg armed_q;
    reg [4:0] arbPos_q;

    // Previous values for edge detection
    reg errPassive_q;
    reg errStatus_q;
    reg busStatus_q;
    reg overrun_q;
    reg txBuf_q;

    // Values reported at setup, used at access
    reg [7:1] rdFlags_q;
    reg rdFrozen_q;

    // Bus decode
    wire [5:0] idx;
    reg hit;
    reg [31:0] rdMux;
    wire setup;
    wire access;
    wire wrEn;
    wire rdEn;

    // Event decode
    wire [7:1] ev;
    wire [7:1] clrMask;
    wire sleepReq;
    wire sleepRefused;
    wire wakeByBus;
    wire releaseCmd;
    wire captureNow;
    wire rearm;
    reg sleep_d;
    wire irq_d;

    assign idx = paddr[7:2];
    assign setup = psel & ~penable;
    assign access = psel & penable & pready;
    assign wrEn = access & pwrite & hit;
    assign rdEn = access & ~pwrite & hit;

    // Address decode; misaligned or unmapped offsets miss
    always @* begin
        hit = 1'b0;
        if (paddr[1:0] == 2'b00) begin
            case (idx)
                `IDX_CTRL: begin
                    hit = 1'b1;
                end
                `IDX_CMD: begin
                    hit = 1'b1;
                end
                `IDX_FLAGS: begin
                    hit = 1'b1;
                end
                `IDX_ENABLE: begin
                    hit = 1'b1;
                end
                `IDX_ARBPOS: begin
                    hit = 1'b1;
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
        end
    end

    // Read data selection
    always @* begin
        rdMux = 32'h0000_0000;
        case (idx)
            `IDX_CTRL: begin
                rdMux[`CTRL_SLEEP_BIT] = sleepMode;
            end
            `IDX_FLAGS: begin
                rdMux[7:1] = flags_q;
                rdMux[`BIT_RX] = rxFlag_q;
            end
            `IDX_ENABLE: begin
                rdMux[7:0] = enable_q;
            end
            `IDX_ARBPOS: begin
                // Upper bits stay zero
                rdMux[4:0] = arbPos_q;
            end
            default: begin
                rdMux = 32'h0000_0000;
            end
        endcase
        if (!hit) begin
            rdMux = 32'h0000_0000;
        end
    end

    // Enable register next value, writable in every mode
    always @* begin
        enable_d = enable_q;
        if (wrEn && idx == `IDX_ENABLE) begin
            enable_d = pwdata[7:0];
        end
    end

    // Sleep handling
    assign sleepReq = wrEn & (idx == `IDX_CTRL) & pwdata[`CTRL_SLEEP_BIT] & ~sleepMode;
    assign sleepRefused = sleepReq & (busActive | ~intOut_b);
    assign wakeByBus = sleepMode & busActive;

    always @* begin
        sleep_d = sleepMode;
        if (wakeByBus) begin
            sleep_d = 1'b0;
        end else if (wrEn && idx == `IDX_CTRL) begin
            sleep_d = pwdata[`CTRL_SLEEP_BIT] & ~sleepRefused;
        end
    end

    // Release receive buffer command
    assign releaseCmd = wrEn & (idx == `IDX_CMD) & pwdata[`CMD_RELEASE_BIT];

    // Arbitration loss capture
    assign captureNow = arbLossEvt & armed_q;
    assign rearm = rdEn & (idx == `IDX_ARBPOS) & rdFrozen_q;

    // Source events
    assign ev[`BIT_BUS_ERR] = busErrorEvt;
    assign ev[`BIT_ARB_LOSS] = captureNow;
    assign ev[`BIT_ERR_PASSIVE] = errPassive ^ errPassive_q;
    assign ev[`BIT_WAKEUP] = wakeByBus | sleepRefused;
    assign ev[`BIT_OVERRUN] = overrunStatus & ~overrun_q;
    assign ev[`BIT_ERR_WARN] = (errStatus ^ errStatus_q) | (busStatus ^ busStatus_q);
    assign ev[`BIT_TX_DONE] = txBufReleased & ~txBuf_q;

    // Only the flags that were reported are cleared by the read
    assign clrMask = (rdEn && idx == `IDX_FLAGS) ? rdFlags_q : 7'h00;

    // Sticky flags; a new event wins over a clear in the same cycle
    genvar i;
    generate
        for (i = 1; i < 8; i = i + 1) begin : gFlag
            assign flags_d[i] = (ev[i] & enable_q[i]) | (flags_q[i] & ~clrMask[i]);
        end
    endgenerate

    // Receive flag is level-derived and held low across a release
    always @* begin
        rxFlag_d = enable_d[`BIT_RX] & rxBufFull;
        if (releaseCmd || rxRelease) begin
            rxFlag_d = 1'b0;
        end
    end

    assign irq_d = ~((|flags_d) | rxFlag_d);

    // Ready stands for exactly the first access cycle
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    // Read data is taken at setup and held until the next setup
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
        end else begin
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : rdMux;
            end
        end
    end

    // Unmapped and misaligned offsets are refused
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pslverr <= 1'b0;
        end else begin
            if (setup) begin
                pslverr <= ~hit;
            end
        end
    end

    // Flags as reported; only these may be cleared by the read
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdFlags_q <= `FLAGS_RST;
        end else begin
            if (setup) begin
                rdFlags_q <= flags_q;
            end
        end
    end

    // A capture read re-arms only if the position was frozen when read
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdFrozen_q <= 1'b0;
        end else begin
            if (setup) begin
                rdFrozen_q <= ~armed_q;
            end
        end
    end

    // Enable register
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enable_q <= `ENABLE_RST;
        end else begin
            enable_q <= enable_d;
        end
    end

    // Sticky flags
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_q <= `FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Receive flag
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rxFlag_q <= 1'b0;
        end else begin
            rxFlag_q <= rxFlag_d;
        end
    end

    // Interrupt output follows the next flag state, so it moves with the flags
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            intOut_b <= 1'b1;
        end else begin
            intOut_b <= irq_d;
        end
    end

    // Position freezes on capture until the capture register is read
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            arbPos_q <= `ARBPOS_RST;
        end else begin
            if (captureNow) begin
                arbPos_q <= arbLossBitPos;
            end
        end
    end

    // Arming; a capture in the re-arming cycle cannot occur, capture wins anyway
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            armed_q <= 1'b1;
        end else begin
            if (captureNow) begin
                armed_q <= 1'b0;
            end else if (rearm) begin
                armed_q <= 1'b1;
            end
        end
    end

    // Status inputs share this clock, so one history stage finds their edges
    // Reset history matches the idle level of each input, so no false edge

    // Error passive level one clock ago
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            errPassive_q <= 1'b0;
        end else begin
            errPassive_q <= errPassive;
        end
    end

    // Error status one clock ago
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            errStatus_q <= 1'b0;
        end else begin
            errStatus_q <= errStatus;
        end
    end

    // Bus status one clock ago
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busStatus_q <= 1'b0;
        end else begin
            busStatus_q <= busStatus;
        end
    end

    // Overrun status one clock ago
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            overrun_q <= 1'b0;
        end else begin
            overrun_q <= overrunStatus;
        end
    end

    // Transmit buffer status one clock ago
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            txBuf_q <= 1'b0;
        end else begin
            txBuf_q <= txBufReleased;
        end
    end

    // Sleep state
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sleepMode <= 1'b0;
        end else begin
            sleepMode <= sleep_d;
        end
    end

    // One-cycle release pulse to the receive FIFO
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rxRelease <= 1'b0;
        end else begin
            rxRelease <= releaseCmd;
        end
    end

endmodule
`default_nettype wire

// ==== bench/can_irq_chk.sv ====
// Port checker for the interrupt enable and capture block
`timescale 1ns/1ps
`default_nettype none
module can_irq_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Controller side
    input wire logic busActive,
    input wire logic intOut_b,
    input wire logic sleepMode,
    input wire logic rxRelease
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire logic acc = psel && penable && pready;
    wire logic sleepWr = acc && pwrite && paddr == 8'h00 && pwdata[4];
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    misalign_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    capture_upper_a: assert property (pready && !pwrite && paddr == 8'h2c |-> prdata[31:5] == 27'h0)
        else $error("capture upper bits not zero");
    sleep_refuse_a: assert property (sleepWr && !sleepMode && (busActive || !intOut_b) |=> !sleepMode)
        else $error("sleep entered while busy");
    sleep_enter_a: assert property (sleepWr && !busActive && intOut_b |=> sleepMode)
        else $error("sleep not entered");
    wake_exit_a: assert property (sleepMode && busActive |=> !sleepMode)
        else $error("no wake on bus activity");
    release_pulse_a: assert property (acc && pwrite && paddr == 8'h04 && pwdata[2] |=> rxRelease ##1 !rxRelease)
        else $error("release pulse wrong");
endmodule
`default_nettype wire

// ==== bench/apb_host.sv ====
// Host model issuing single register transfers
`timescale 1ns/1ps
`default_nettype none
module apb_host (
    // Clock
    input wire logic clk,
    // Request
    output var logic psel = 1'b0,
    output var logic penable = 1'b0,
    output var logic pwrite = 1'b0,
    output var logic [7:0] paddr = 8'h00,
    output var logic [31:0] pwdata = 32'h0000_0000,
    // Answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
            output logic [31:0] r, output logic e, output logic ok);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        ok = pready;
        // Released lines show a changed value, not the old one
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~pwdata;
    endtask
endmodule
`default_nettype wire

// ==== bench/tb_can_irq_enable_arb_capture.sv ====
// Testbench of the interrupt enable and capture block
`timescale 1ns/1ps
`default_nettype none
module tb_can_irq_enable_arb_capture;
    logic clk = 1'b0, rst_b = 1'b0, busErrorEvt = 1'b0, arbLossEvt = 1'b0, errPassive = 1'b0;
    logic errStatus = 1'b0, busStatus = 1'b0, overrunStatus = 1'b0, txBufReleased = 1'b0;
    logic busActive = 1'b0;
    logic [4:0] arbLossBitPos = 5'h00;
    int msgs, fails, compares, taken;
    wire logic psel, penable, pwrite, pready, pslverr, intOut_b, sleepMode, rxRelease;
    wire logic [7:0] paddr;
    wire logic [31:0] pwdata, prdata;
    wire logic rxBufFull = taken < msgs;
    apb_host host (
        .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );
    can_irq_enable_arb_capture dut (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .busErrorEvt(busErrorEvt), .arbLossEvt(arbLossEvt), .arbLossBitPos(arbLossBitPos),
        .errPassive(errPassive), .errStatus(errStatus), .busStatus(busStatus),
        .overrunStatus(overrunStatus), .txBufReleased(txBufReleased), .rxBufFull(rxBufFull),
        .busActive(busActive), .intOut_b(intOut_b), .sleepMode(sleepMode),
        .rxRelease(rxRelease)
    );
    initial begin
        forever #10 clk = ~clk;
    end
    // Receive FIFO drops one message per release pulse
    always @(posedge clk) begin
        if (rxRelease && taken < msgs) taken <= taken + 1;
    end
    task automatic complete_run;
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
            output logic [31:0] r, output logic e);
        logic ok;
        host.xfer(w, a, d, r, e, ok);
        if (ok !== 1'b1) begin
            fails++;
            complete_run();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        xfer(1'b0, a, 8'h00, r, e);
        cmp(r, x);
    endtask
    task automatic pin(input logic x);
        #1;
        cmp({31'h0000_0000, intOut_b}, {31'h0000_0000, x});
    endtask
    task automatic trig(input int i, input logic v);
        @(posedge clk);
        case (i)
            7: busErrorEvt <= 1'b1;
            6: arbLossEvt <= 1'b1;
            5: errPassive <= v;
            3: overrunStatus <= v;
            2: errStatus <= v;
            1: txBufReleased <= v;
            default: busActive <= v;
        endcase
        @(posedge clk);
        busErrorEvt <= 1'b0;
        arbLossEvt <= 1'b0;
    endtask
    initial begin
        logic [31:0] r;
        logic e;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rd(8'h10, 32'h0000_0000);
        wr(8'h10, 8'ha5);
        rd(8'h10, 32'h0000_00a5);
        wr(8'h2c, 8'hff);
        rd(8'h2c, 32'h0000_0000);
        xfer(1'b0, 8'h20, 8'h00, r, e);
        cmp({31'h0000_0000, e}, 32'h0000_0001);
        xfer(1'b1, 8'h12, 8'hff, r, e);
        cmp({31'h0000_0000, e}, 32'h0000_0001);
        rd(8'h10, 32'h0000_00a5);
        arbLossBitPos <= 5'h0b;
        for (int en = 0; en < 2; en++) begin
            for (int i = 7; i > 0; i--) begin
                wr(8'h10, en ? (8'h01 << i) : 8'h00);
                if (i == 4) wr(8'h00, 8'h10);
                trig(i, 1'b1);
                pin(!en);
                rd(8'h0c, en ? (32'h0000_0001 << i) : 32'h0000_0000);
                pin(1'b1);
                wr(8'h10, 8'h00);
                trig(i, 1'b0);
                xfer(1'b0, 8'h2c, 8'h00, r, e);
                if (en && i == 6) cmp(r, 32'h0000_000b);
            end
        end
        wr(8'h10, 8'h40);
        arbLossBitPos <= 5'h1f;
        trig(6, 1'b1);
        arbLossBitPos <= 5'h03;
        trig(6, 1'b1);
        rd(8'h0c, 32'h0000_0040);
        pin(1'b1);
        trig(6, 1'b1);
        pin(1'b1);
        rd(8'h2c, 32'h0000_001f);
        trig(6, 1'b1);
        pin(1'b0);
        rd(8'h2c, 32'h0000_0003);
        busActive <= 1'b1;
        wr(8'h10, 8'h10);
        wr(8'h00, 8'h10);
        pin(1'b0);
        rd(8'h00, 32'h0000_0000);
        rd(8'h0c, 32'h0000_0050);
        busActive <= 1'b0;
        msgs <= 2;
        wr(8'h10, 8'h01);
        pin(1'b0);
        rd(8'h0c, 32'h0000_0001);
        rd(8'h0c, 32'h0000_0001);
        wr(8'h04, 8'h04);
        pin(1'b1);
        repeat (2) @(posedge clk);
        rd(8'h0c, 32'h0000_0001);
        wr(8'h04, 8'h04);
        repeat (2) @(posedge clk);
        pin(1'b1);
        @(posedge clk);
        msgs <= 3;
        repeat (2) @(posedge clk);
        pin(1'b0);
        wr(8'h10, 8'h00);
        pin(1'b1);
        complete_run();
    end
endmodule
bind can_irq_enable_arb_capture can_irq_chk chk (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busActive(busActive), .intOut_b(intOut_b), .sleepMode(sleepMode), .rxRelease(rxRelease)
);
`default_nettype wire
